// ### dv/els_bus_model.sv
// memory side of the bus: sixteen words, lane n holds bits 8n+7:8n
// assumes requests are held until bus_ack, as the steering block does
`timescale 1ns/1ps
`default_nettype none

module els_bus_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic [29:0] bus_addr,
    input wire logic [3:0] bus_be,
    input wire logic [31:0] bus_wdata,
    output logic bus_ack,
    output logic [31:0] bus_rdata
);
    // word store, indexed by the low word address bits
    logic [31:0] mem [0:15];
    // cycles waited on the current request
    logic [1:0] wait_cnt;

    // answer after 0 or 3 cycles; read data is junk outside the ack cycle
    // so a late sample never sees a stale but correct value
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_ack <= 1'b0;
            wait_cnt <= 2'h0;
            bus_rdata <= 32'h0000_0000;
        end else if (bus_ack) begin
            bus_ack <= 1'b0;
            wait_cnt <= 2'h0;
            bus_rdata <= ~bus_rdata;
            for (int i = 0; i < 4; i++) begin
                if (bus_we && bus_be[i]) begin
                    mem[bus_addr[3:0]][8*i+:8] <= bus_wdata[8*i+:8];
                end
            end
        end else if (bus_req) begin
            if (!slow || wait_cnt == 2'h3) begin
                bus_ack <= 1'b1;
                bus_rdata <= mem[bus_addr[3:0]];
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/els_steer_bench.sv
// self-checking bench for the endian lane steering block
// assumes els_bus_model answers the bus side; inputs change at negedge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module els_steer_bench;
    import els_pkg::*;
    logic core_clk = 0;
    logic resetn = 0;
    logic bso = 1;
    logic req = 0;
    logic we = 0;
    logic slow = 0;
    els_size_t sz = ELS_SZ_WORD;
    logic [31:0] addr = 0;
    logic [31:0] wdata = 0;
    logic core_ack, core_err, bus_req, bus_we, bus_ack;
    logic [31:0] core_rdata, bus_wdata, bus_rdata, got_rd, cap_wd;
    logic [29:0] bus_addr, cap_addr;
    logic [3:0] bus_be, cap_be;
    logic got_err, cap_we;
    int nbus = 0;
    int bad_count = 0;
    int n_tests = 0;

    els_steer els_steer_inst (.core_clk(core_clk), .resetn(resetn),
        .byte_order_select(bso), .core_req(req), .core_we(we),
        .core_size(sz), .core_addr(addr), .core_wdata(wdata),
        .core_ack(core_ack), .core_err(core_err), .core_rdata(core_rdata),
        .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata));
    els_bus_model els_bus_model_inst (.core_clk(core_clk), .resetn(resetn),
        .slow(slow), .bus_req(bus_req), .bus_we(bus_we),
        .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    // 40 mhz core clock
    always #12.5 core_clk = ~core_clk;

    // grab what the bus took, at the edge where it took it
    always @(posedge core_clk) begin
        if (bus_req && bus_ack) begin
            cap_be <= bus_be;
            cap_wd <= bus_wdata;
            cap_addr <= bus_addr;
            cap_we <= bus_we;
            nbus <= nbus + 1;
        end
    end

    // one core access: offer, drop after the taking edge, await ack
    task automatic acc(input logic m, input logic w, input els_size_t s,
                       input logic [31:0] a, input logic [31:0] d);
        int i;
        @(negedge core_clk);
        bso = m;
        we = w;
        sz = s;
        addr = a;
        wdata = d;
        req = 1;
        @(negedge core_clk);
        req = 0;
        for (i = 0; i < 20 && core_ack !== 1'b1; i++) @(negedge core_clk);
        `CHK("ack", 1'b1, core_ack)
        got_err = core_err;
        got_rd = core_rdata;
    endtask

    // words in both modes, stored and read back
    task automatic t_word;
        acc(1, 1, ELS_SZ_WORD, 32'h0000_1000, 32'h0102_0304);
        `CHK("wd_le", 32'h0102_0304, cap_wd)
        `CHK("be_w", 4'hf, cap_be)
        `CHK("adr", 30'h0000_0400, cap_addr)
        `CHK("we_w", 1'b1, cap_we)
        acc(0, 1, ELS_SZ_WORD, 32'h0000_1004, 32'h0102_0304);
        `CHK("wd_be", 32'h0403_0201, cap_wd)
        acc(0, 0, ELS_SZ_WORD, 32'h0000_1004, 32'h0);
        `CHK("rd_be", 32'h0102_0304, got_rd)
        `CHK("we_r", 1'b0, cap_we)
        acc(1, 0, ELS_SZ_WORD, 32'h0000_1004, 32'h0);
        `CHK("rd_le", 32'h0403_0201, got_rd)
    endtask

    // halves stored at both offsets in both modes; loaded at offset 0 when little, at both offsets when big
    task automatic t_half;
        acc(1, 1, ELS_SZ_HALF, 32'h0000_1000, 32'hffff_0304);
        `CHK("h0_le", 16'h0304, cap_wd[15:0])
        `CHK("h0_be", 4'h3, cap_be)
        acc(1, 1, ELS_SZ_HALF, 32'h0000_1002, 32'hffff_0304);
        `CHK("h2_le", 16'h0304, cap_wd[31:16])
        `CHK("h2_be", 4'hc, cap_be)
        acc(1, 0, ELS_SZ_HALF, 32'h0000_1000, 32'h0);
        `CHK("h0_rd", 32'h0000_0304, got_rd)
        acc(0, 1, ELS_SZ_HALF, 32'h0000_1008, 32'h0000_0304);
        `CHK("h0_bg", 16'h0403, cap_wd[15:0])
        acc(0, 1, ELS_SZ_HALF, 32'h0000_100a, 32'h0000_0304);
        `CHK("h2_bg", 16'h0403, cap_wd[31:16])
        `CHK("h2_bbe", 4'hc, cap_be)
        acc(0, 0, ELS_SZ_HALF, 32'h0000_100a, 32'h0);
        `CHK("h2_rd", 32'h0000_0304, got_rd)
        acc(0, 0, ELS_SZ_HALF, 32'h0000_1008, 32'h0);
        `CHK("h0_brd", 32'h0000_0304, got_rd)
    endtask

    // bytes at every offset; lanes outside the enable stay put
    task automatic t_byte;
        acc(1, 1, ELS_SZ_WORD, 32'h0000_1010, 32'haabb_ccdd);
        acc(1, 1, ELS_SZ_BYTE, 32'h0000_1011, 32'h5566_7704);
        `CHK("b_be", 4'h2, cap_be)
        for (int n = 0; n < 4; n++) begin
            acc(n[0], 1, ELS_SZ_BYTE, 32'h0000_1020 + n, 32'h0000_0004);
            `CHK("b_lane", 8'h04, cap_wd[8*n+:8])
            `CHK("b_en", 4'h1 << n, cap_be)
            acc(n[1], 0, ELS_SZ_BYTE, 32'h0000_1010 + n, 32'h0);
            `CHK("b_rd", (32'haabb_04dd >> (8 * n)) & 32'hff, got_rd)
        end
        acc(1, 0, ELS_SZ_WORD, 32'h0000_1020, 32'h0);
        `CHK("b_all", 32'h0404_0404, got_rd)
    endtask

    // base byte of a stored word per mode, with a slow bus
    task automatic t_base;
        slow = 1;
        acc(1, 1, ELS_SZ_WORD, 32'h0000_1030, 32'h0405_0607);
        acc(1, 0, ELS_SZ_BYTE, 32'h0000_1030, 32'h0);
        `CHK("base_le", 32'h0000_0007, got_rd)
        acc(0, 1, ELS_SZ_WORD, 32'h0000_1034, 32'h0405_0607);
        acc(0, 0, ELS_SZ_BYTE, 32'h0000_1034, 32'h0);
        `CHK("base_be", 32'h0000_0004, got_rd)
        slow = 0;
    endtask

    // misaligned accesses are refused without a bus cycle
    task automatic t_mis;
        int n0;
        n0 = nbus;
        acc(1, 1, ELS_SZ_WORD, 32'h0000_1041, 32'h1);
        `CHK("err_w", 1'b1, got_err)
        acc(0, 0, ELS_SZ_HALF, 32'h0000_1043, 32'h0);
        `CHK("err_h", 1'b1, got_err)
        `CHK("no_bus", n0, nbus)
        acc(1, 0, ELS_SZ_HALF, 32'h0000_1042, 32'h0);
        `CHK("ok_h", 1'b0, got_err)
        `CHK("ok_hd", 32'h0000_0304, got_rd)
    endtask

    // print counts and verdict, then stop
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        resetn = 1;
        repeat (3) @(negedge core_clk);
        `CHK("rst_req", 1'b0, bus_req)
        `CHK("rst_be", 4'h0, bus_be)
        t_word;
        t_half;
        t_byte;
        t_base;
        t_mis;
        end_of_test;
    end

    // watchdog, well past the hundred or so cycles the tests need
    initial begin
        #(25 * 5000);
        bad_count++;
        $display("[ERR] watchdog exp done got hang");
        end_of_test;
    end
endmodule
`default_nettype wire

// ### rtl/els_byte_rev.sv
// byte order reverser for one 32-bit word
// assumes the caller decides when reversal applies; pure combinational
`timescale 1ns/1ps
`default_nettype none

module els_byte_rev (
    input wire logic [31:0] din,
    input wire logic swap_en,
    output logic [31:0] dout
);
    assign dout = swap_en ? {din[7:0], din[15:8], din[23:16], din[31:24]}
                          : din;
endmodule

`default_nettype wire

// ### rtl/els_map.svh
// constants for the endian lane steering block: lane masks, codes, resets
// assumes a 32-bit bus of four byte lanes, lane n carrying bits 8n+7:8n
`ifndef ELS_MAP_SVH
`define ELS_MAP_SVH

// byte-order select value that means little endian
`define ELS_ORDER_LE 1'b1
// byte enables of a full word, a low half and byte lane 0
`define ELS_BE_WORD 4'hf
`define ELS_BE_HALF 4'h3
`define ELS_BE_BYTE 4'h1
// reset value of every data holding flop
`define ELS_DATA_RST 32'h0000_0000
`define ELS_ADDR_RST 30'h0000_0000
`define ELS_BE_RST 4'h0

`endif

// ### rtl/els_pkg.sv
// types shared by the endian lane steering block
// assumes the constant header els_map.svh carries the numbers
package els_pkg;

    // width of a core access
    typedef enum logic [1:0] {
        ELS_SZ_BYTE = 2'h0,
        ELS_SZ_HALF = 2'h1,
        ELS_SZ_WORD = 2'h2
    } els_size_t;

    // request sequencer, one-hot
    typedef enum logic [1:0] {
        ELS_ST_IDLE = 2'b01,
        ELS_ST_BUS = 2'b10
    } els_state_t;

    // all state of the steering module except its two reset release flops
    typedef struct packed {
        els_state_t st;
        logic bus_req;
        logic bus_we;
        logic [29:0] bus_addr;
        logic [3:0] bus_be;
        logic [31:0] bus_wdata;
        logic core_ack;
        logic core_err;
        logic [31:0] core_rdata;
        logic [1:0] sz;
        logic [1:0] off;
        logic le_mode;
    } els_regs_t;

endpackage

// ### rtl/els_steer.sv
// endian lane steering between the core load/store path and the bus
// assumes the bus holds bus_ack low until it has taken a request, and
// that byte_order_select comes from the processor status word
//
// Functional notes
// - host bus always little endian lanes
// - big endian: base address is MSB
// - little endian: base address is LSB
// - conversion is pure four-byte reversal
// - little endian word passes unchanged
// - little endian halves use lanes 1:0, 3:2
// - byte at offset n uses lane n
// - base byte read: 0x04 big, 0x07 little
// - select bit one means little endian
// - swap in cache path, lanes never swapped
`timescale 1ns/1ps
`default_nettype none
`include "els_map.svh"

module els_steer (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic byte_order_select,
    input wire logic core_req,
    input wire logic core_we,
    input wire els_pkg::els_size_t core_size,
    input wire logic [31:0] core_addr,
    input wire logic [31:0] core_wdata,
    output logic core_ack,
    output logic core_err,
    output logic [31:0] core_rdata,
    output logic bus_req,
    output logic bus_we,
    output logic [29:0] bus_addr,
    output logic [3:0] bus_be,
    output logic [31:0] bus_wdata,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata
);
    import els_pkg::*;

    // lanes an access touches; used by the request and the checks
    function automatic logic [3:0] lane_mask(els_size_t sz, logic [1:0] off);
        logic [3:0] m;
        m = `ELS_BE_BYTE << off;
        if (sz == ELS_SZ_WORD) begin
            m = `ELS_BE_WORD;
        end else if (sz == ELS_SZ_HALF) begin
            m = off[1] ? (`ELS_BE_HALF << 2) : `ELS_BE_HALF;
        end
        return m;
    endfunction

    // byte carried on lane n of a bus word
    function automatic logic [7:0] lane_byte(logic [31:0] w, logic [1:0] n);
        logic [7:0] b;
        b = w[8*n +: 8];
        return b;
    endfunction

    // misaligned halves and words are refused rather than split
    function automatic logic misaligned(els_size_t sz, logic [1:0] off);
        logic bad;
        bad = 1'b0;
        if (sz == ELS_SZ_WORD) begin
            bad = (off != 2'h0);
        end else if (sz == ELS_SZ_HALF) begin
            bad = off[0];
        end
        return bad;
    endfunction

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    els_regs_t s_reg; // all block state but the reset release flops
    els_regs_t s_next; // its next value
    logic [31:0] wr_conv; // store data after optional reversal
    logic [31:0] rd_conv; // load data after optional reversal
    logic big_now; // big endian for the access being offered
    logic take; // request accepted this cycle

    assign big_now = (byte_order_select != `ELS_ORDER_LE);

    els_byte_rev u_wr_rev (
        .din(core_wdata),
        .swap_en(big_now),
        .dout(wr_conv)
    );

    // load side uses the mode latched with the request
    els_byte_rev u_rd_rev (
        .din(bus_rdata),
        .swap_en(!s_reg.le_mode),
        .dout(rd_conv)
    );

    assign take = (s_reg.st == ELS_ST_IDLE) && core_req
                  && !misaligned(core_size, core_addr[1:0]);

    // sequencer and steering
    always_comb begin
        s_next = s_reg;
        s_next.core_ack = 1'b0;
        s_next.core_err = 1'b0;
        unique case (s_reg.st)
            ELS_ST_IDLE: begin
                if (core_req && !take) begin
                    // refused: answer with error, no bus cycle
                    s_next.core_ack = 1'b1;
                    s_next.core_err = 1'b1;
                end else if (take) begin
                    s_next.st = ELS_ST_BUS;
                    s_next.bus_req = 1'b1;
                    s_next.bus_we = core_we;
                    s_next.sz = core_size;
                    s_next.off = core_addr[1:0];
                    s_next.le_mode = byte_order_select;
                    s_next.bus_addr = core_addr[31:2];
                    s_next.bus_be = core_we
                        ? lane_mask(core_size, core_addr[1:0])
                        : `ELS_BE_WORD;
                    unique case (core_size)
                        // word as is; swap when big
                        ELS_SZ_WORD: s_next.bus_wdata = wr_conv;
                        ELS_SZ_HALF: s_next.bus_wdata = big_now
                            ? {2{wr_conv[31:16]}}
                            : {2{core_wdata[15:0]}};
                        ELS_SZ_BYTE: s_next.bus_wdata = {4{core_wdata[7:0]}};
                        default: s_next.bus_wdata = core_wdata;
                    endcase
                end
            end
            ELS_ST_BUS: begin
                if (bus_ack) begin
                    s_next.st = ELS_ST_IDLE;
                    s_next.bus_req = 1'b0;
                    s_next.core_ack = 1'b1;
                    if (!s_reg.bus_we) begin
                        unique case (s_reg.sz)
                            ELS_SZ_WORD: s_next.core_rdata = rd_conv;
                            ELS_SZ_HALF: s_next.core_rdata = {16'h0000,
                                s_reg.le_mode
                                ? bus_rdata[16*s_reg.off[1] +: 16]
                                : rd_conv[16*(!s_reg.off[1]) +: 16]};
                            ELS_SZ_BYTE: s_next.core_rdata = {24'h000000,
                                lane_byte(bus_rdata, s_reg.off)};
                            default: s_next.core_rdata = bus_rdata;
                        endcase
                    end
                end
            end
            default: begin
                // illegal one-hot code: recover to idle
                s_next.st = ELS_ST_IDLE;
                s_next.bus_req = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s_reg.st <= ELS_ST_IDLE;
            s_reg.bus_req <= 1'b0;
            s_reg.bus_we <= 1'b0;
            s_reg.bus_addr <= `ELS_ADDR_RST;
            s_reg.bus_be <= `ELS_BE_RST;
            s_reg.bus_wdata <= `ELS_DATA_RST;
            s_reg.core_ack <= 1'b0;
            s_reg.core_err <= 1'b0;
            s_reg.core_rdata <= `ELS_DATA_RST;
            s_reg.sz <= ELS_SZ_WORD;
            s_reg.off <= 2'h0;
            s_reg.le_mode <= `ELS_ORDER_LE;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign core_ack = s_reg.core_ack;
    assign core_err = s_reg.core_err;
    assign core_rdata = s_reg.core_rdata;
    assign bus_req = s_reg.bus_req;
    assign bus_we = s_reg.bus_we;
    assign bus_addr = s_reg.bus_addr;
    assign bus_be = s_reg.bus_be;
    assign bus_wdata = s_reg.bus_wdata;

    // checks
    sequence s_take_wr(els_size_t sz, logic bo);
        take && core_we && core_size == sz && byte_order_select == bo;
    endsequence
    sequence s_rd_done(els_size_t sz);
        bus_req && bus_ack && !bus_we && s_reg.sz == sz;
    endsequence
    property p_addr_inv;
        @(posedge core_clk) disable iff (!rst_n_reg)
        take |=> bus_req && bus_addr == $past(core_addr[31:2]);
    endproperty
    a_addr_inv: assert property (p_addr_inv)
        else $error("bus address not the core word address");
    property p_word_le;
        @(posedge core_clk) disable iff (!rst_n_reg)
        s_take_wr(ELS_SZ_WORD, 1'b1) |=> bus_wdata == $past(core_wdata);
    endproperty
    a_word_le: assert property (p_word_le)
        else $error("little endian word altered");
    property p_word_be;
        @(posedge core_clk) disable iff (!rst_n_reg)
        s_take_wr(ELS_SZ_WORD, 1'b0) |=> bus_wdata == {
            $past(core_wdata[7:0]), $past(core_wdata[15:8]),
            $past(core_wdata[23:16]), $past(core_wdata[31:24])};
    endproperty
    a_word_be: assert property (p_word_be)
        else $error("big endian word not byte reversed");
    property p_half_le;
        @(posedge core_clk) disable iff (!rst_n_reg)
        s_take_wr(ELS_SZ_HALF, 1'b1) |=> bus_be == ($past(core_addr[1])
            ? 4'hc : 4'h3) && bus_wdata[15:0] == $past(core_wdata[15:0])
            && bus_wdata[31:16] == $past(core_wdata[15:0]);
    endproperty
    a_half_le: assert property (p_half_le)
        else $error("little endian half on wrong lanes");
    property p_half_be;
        @(posedge core_clk) disable iff (!rst_n_reg)
        s_take_wr(ELS_SZ_HALF, 1'b0) |=> bus_wdata[15:0] ==
            {$past(core_wdata[7:0]), $past(core_wdata[15:8])};
    endproperty
    a_half_be: assert property (p_half_be)
        else $error("big endian half not swapped");
    property p_byte_lane;
        @(posedge core_clk) disable iff (!rst_n_reg)
        take && core_we && core_size == ELS_SZ_BYTE |=>
            bus_be == (4'h1 << $past(core_addr[1:0]))
            && lane_byte(bus_wdata, s_reg.off) == $past(core_wdata[7:0]);
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte not on its lane");
    property p_rd_byte;
        @(posedge core_clk) disable iff (!rst_n_reg)
        s_rd_done(ELS_SZ_BYTE) |=> core_ack && core_rdata ==
            {24'h000000, lane_byte($past(bus_rdata), $past(s_reg.off))};
    endproperty
    a_rd_byte: assert property (p_rd_byte)
        else $error("byte load from wrong lane");
    property p_rd_half_le;
        @(posedge core_clk) disable iff (!rst_n_reg)
        s_rd_done(ELS_SZ_HALF) ##0 s_reg.le_mode && !s_reg.off[1]
            |=> core_rdata == {16'h0000, $past(bus_rdata[15:0])};
    endproperty
    a_rd_half_le: assert property (p_rd_half_le)
        else $error("little endian half load altered");
    property p_be_only;
        @(posedge core_clk) disable iff (!rst_n_reg)
        bus_req && bus_we |-> (bus_be & ~lane_mask(els_size_t'(s_reg.sz),
            s_reg.off)) == 4'h0 && bus_be != 4'h0;
    endproperty
    a_be_only: assert property (p_be_only)
        else $error("write enables a lane not addressed");
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n_reg)
        bus_req && !bus_ack |=> bus_req && $stable(bus_wdata)
            && $stable(bus_be) && $stable(bus_addr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("bus request changed before acceptance");
    property p_done;
        @(posedge core_clk) disable iff (!rst_n_reg)
        bus_req && bus_ack |=> core_ack && !core_err && !bus_req;
    endproperty
    a_done: assert property (p_done)
        else $error("bus completion not answered");
endmodule

`default_nettype wire
